// ==== verilog/hbsc_device.sv ====
// device end: host bus slave, chip selects, reset sequencer, watchdog
`timescale 1ns/1ns
module hbsc_device
  import hbsc_pkg::*;
#(
  parameter int RESET_CYCLES = RESET_SEQ_CYC,
  parameter int WDOG_CYCLES  = WDOG_CYC
)(
  input  wire logic ref_clk,
  input  wire logic resetn,
  hbsc_if.device    bus,
  input  wire logic reset_in_n,
  input  wire logic ack_advance_select,
  input  wire logic watchdog_enable,
  input  wire logic irq_request,
  input  wire logic col_strobe_bank1_n,
  input  wire logic col_strobe_bank2_n,
  output logic      rom_select_n,
  output logic      io_select_n,
  output logic      rom_shadow,
  output logic      bank1_present,
  output logic      bank2_present
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  hbsc_rst_t   rst_state, next_rst_state;
  logic [31:0] rst_cnt, next_rst_cnt;
  logic [2:0]  fetch_cnt, next_fetch_cnt;
  logic        next_rom_shadow, next_bank1, next_bank2;
  logic [15:0] regs [REG_WORDS];
  logic [15:0] next_regs [REG_WORDS];
  logic [3:0]  ack_cnt, next_ack_cnt;
  logic        in_cycle, next_in_cycle;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic        next_rom_sel, next_io_sel, next_ack_n, next_ack_oe;
  logic [15:0] next_dout;
  logic        next_dout_oe, next_fault_oe, next_irq_oe, next_rst_oe;
  logic        strobe, hit_rom, hit_io, hit_reg, seq;
  logic [2:0]  ridx;

  assign strobe  = !bus.upper_byte_strobe_n || !bus.lower_byte_strobe_n;
  assign hit_rom = ((bus.addr & ROM_MASK) == ROM_BASE) || rom_shadow;
  assign hit_io  = (bus.addr & IO_MASK) == IO_BASE;
  assign hit_reg = (bus.addr & REG_MASK) == REG_BASE;
  assign ridx    = bus.addr[2:0];
  assign seq     = rst_state == HBSC_RS_SEQ;

  // ----------------------------------------
  // reset sequencer
  // ----------------------------------------
  always_comb
  begin
    next_rst_state  = rst_state;
    next_rst_cnt    = rst_cnt;
    next_fetch_cnt  = fetch_cnt;
    next_rom_shadow = rom_shadow;
    next_bank1      = bank1_present;
    next_bank2      = bank2_present;
    next_rst_oe     = seq;
    unique case (rst_state)
      HBSC_RS_RUN:
      begin
        if (!reset_in_n)
        begin
          next_rst_state  = HBSC_RS_SEQ;
          next_rst_cnt    = '0;
          next_fetch_cnt  = '0;
          next_rom_shadow = 1'b1;
        end
        // shadow ends after the reset fetches complete; a new reset request wins
        else if (rom_shadow && in_cycle && !strobe)
        begin
          next_fetch_cnt = fetch_cnt + 3'h1;
          if (fetch_cnt == 3'(SHADOW_FETCHES - 1))
            next_rom_shadow = 1'b0;
        end
      end
      HBSC_RS_SEQ:
      begin
        next_bank1 = col_strobe_bank1_n;
        next_bank2 = col_strobe_bank2_n;
        if (!reset_in_n)
          next_rst_cnt = '0;
        else if (rst_cnt == 32'(RESET_CYCLES - 1))
          next_rst_state = HBSC_RS_RUN;
        else
          next_rst_cnt = rst_cnt + 32'h1;
      end
      default: next_rst_state = HBSC_RS_SEQ;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_state  <= HBSC_RS_SEQ;
      rst_cnt    <= '0;
      fetch_cnt  <= '0;
      rom_shadow <= 1'b1;
      bank1_present <= 1'b0;
      bank2_present <= 1'b0;
      bus.system_reset_out_oe <= 1'b1;
      bus.halt_out_oe         <= 1'b1;
    end
    else
    begin
      rst_state  <= next_rst_state;
      rst_cnt    <= next_rst_cnt;
      fetch_cnt  <= next_fetch_cnt;
      rom_shadow <= next_rom_shadow;
      bank1_present <= next_bank1;
      bank2_present <= next_bank2;
      bus.system_reset_out_oe <= next_rst_oe;
      bus.halt_out_oe         <= next_rst_oe;
    end
  end
  // open drain: only ever pulls low
  assign bus.system_reset_out_n = 1'b0;
  assign bus.halt_out_n         = 1'b0;
  assign bus.bus_fault_n        = 1'b0;
  assign bus.irq_n              = 1'b0;

  // ----------------------------------------
  // bus cycle, selects, watchdog
  // ----------------------------------------
  always_comb
  begin
    next_in_cycle = in_cycle;
    next_ack_cnt  = ack_cnt;
    next_ack_n    = bus.transfer_ack_n;
    next_ack_oe   = bus.transfer_ack_oe;
    next_dout     = bus.dev_data;
    next_dout_oe  = 1'b0;
    next_wd_cnt   = '0;
    next_fault_oe = 1'b0;
    for (int i = 0; i < REG_WORDS; i++)
      next_regs[i] = regs[i];
    next_rom_sel = !(hit_rom && strobe && !bus.chip_select_n);
    next_io_sel  = !(hit_io && strobe && !bus.chip_select_n);
    next_irq_oe  = irq_request;
    // counts during the sequence too: nobody answers a strobe then
    if (strobe && watchdog_enable)
    begin
      next_wd_cnt = wd_cnt;
      if (wd_cnt == 32'(WDOG_CYCLES - 1))
        next_fault_oe = 1'b1;
      else
        next_wd_cnt = wd_cnt + 32'h1;
    end
    if (!strobe)
    begin
      next_in_cycle = 1'b0;
      next_ack_n    = 1'b1;
      next_ack_oe   = 1'b0;
      next_ack_cnt  = '0;
    end
    else if (!bus.chip_select_n && !seq && !in_cycle)
    begin
      if (ack_cnt == (ack_advance_select ? 4'(ACK_FAST_CYC) : 4'(ACK_SLOW_CYC)))
      begin
        next_in_cycle = 1'b1;
        next_ack_n    = 1'b0;
        next_ack_oe   = 1'b1;
        if (!bus.read_not_write && hit_reg)
        begin
          if (!bus.upper_byte_strobe_n)
            next_regs[ridx][15:8] = bus.host_data[15:8];
          if (!bus.lower_byte_strobe_n)
            next_regs[ridx][7:0] = bus.host_data[7:0];
        end
      end
      else
        next_ack_cnt = ack_cnt + 4'h1;
    end
    if (strobe && bus.read_not_write && !bus.chip_select_n && !seq)
    begin
      next_dout_oe = 1'b1;
      next_dout    = 16'h0000;
      if (hit_reg)
      begin
        if (!bus.upper_byte_strobe_n)
          next_dout[15:8] = regs[ridx][15:8];
        if (!bus.lower_byte_strobe_n)
          next_dout[7:0] = regs[ridx][7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_cycle  <= 1'b0;
      ack_cnt   <= '0;
      wd_cnt    <= '0;
      for (int i = 0; i < REG_WORDS; i++)
        regs[i] <= RESET_DATA;
      rom_select_n        <= 1'b1;
      io_select_n         <= 1'b1;
      bus.transfer_ack_n  <= 1'b1;
      bus.transfer_ack_oe <= 1'b0;
      bus.dev_data        <= RESET_DATA;
      bus.dev_data_oe     <= 1'b0;
      bus.bus_fault_oe    <= 1'b0;
      bus.irq_oe          <= 1'b0;
    end
    else
    begin
      in_cycle  <= next_in_cycle;
      ack_cnt   <= next_ack_cnt;
      wd_cnt    <= next_wd_cnt;
      for (int i = 0; i < REG_WORDS; i++)
        regs[i] <= next_regs[i];
      rom_select_n        <= next_rom_sel;
      io_select_n         <= next_io_sel;
      bus.transfer_ack_n  <= next_ack_n;
      bus.transfer_ack_oe <= next_ack_oe;
      bus.dev_data        <= next_dout;
      bus.dev_data_oe     <= next_dout_oe;
      bus.bus_fault_oe    <= next_fault_oe;
      bus.irq_oe          <= next_irq_oe;
    end
  end
endmodule // hbsc_device

// ==== common/hbsc_pkg.sv ====
// package: constants and types shared by both ends of the host bus port
package hbsc_pkg;
  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 22;  // word address a1..a22
  localparam int DATA_W = 16;
  // ----------------------------------------
  // address map (word addresses)
  // ----------------------------------------
  localparam logic [21:0] ROM_BASE  = 22'h000000;  // 1 mbyte = 512k words
  localparam logic [21:0] ROM_MASK  = 22'h380000;
  localparam logic [21:0] IO_BASE   = 22'h200000;  // 1 kbyte = 512 words
  localparam logic [21:0] IO_MASK   = 22'h3FFE00;
  localparam logic [21:0] REG_BASE  = 22'h27FFC0;  // internal word array
  localparam logic [21:0] REG_MASK  = 22'h3FFFF8;
  localparam int          REG_WORDS = 8;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int RESET_SEQ_NS   = 2000;
  localparam int RESET_SEQ_CYC  = RESET_SEQ_NS / CLK_PERIOD_NS;
  localparam int SHADOW_FETCHES = 4;     // reset fetches mapped to rom
  localparam int WDOG_NS        = 4000;
  localparam int WDOG_CYC       = WDOG_NS / CLK_PERIOD_NS;
  localparam int ACK_SLOW_CYC   = 3;
  localparam int ACK_FAST_CYC   = 1;
  localparam logic [15:0] RESET_DATA = 16'h0000;
  typedef enum logic [1:0] {HBSC_RS_RUN, HBSC_RS_SEQ} hbsc_rst_t;
  typedef enum logic [1:0] {HBSC_H_IDLE, HBSC_H_STROBE, HBSC_H_WAIT_REL} hbsc_host_t;
endpackage

// ==== common/hbsc_if.sv ====
// interface: the asynchronous 16-bit bus between host and device
`timescale 1ns/1ns
interface hbsc_if;
  logic [21:0] addr;
  logic [15:0] host_data;
  logic        host_data_oe;
  logic [15:0] dev_data;
  logic        dev_data_oe;
  logic        upper_byte_strobe_n;
  logic        lower_byte_strobe_n;
  logic        read_not_write;
  logic        chip_select_n;
  logic        transfer_ack_n;
  logic        transfer_ack_oe;
  logic        system_reset_out_n;
  logic        system_reset_out_oe;
  logic        halt_out_n;
  logic        halt_out_oe;
  logic        bus_fault_n;
  logic        bus_fault_oe;
  logic        irq_n;
  logic        irq_oe;
  modport device (
    input  addr, host_data, host_data_oe, upper_byte_strobe_n, lower_byte_strobe_n,
           read_not_write, chip_select_n,
    output dev_data, dev_data_oe, transfer_ack_n, transfer_ack_oe, system_reset_out_n,
           system_reset_out_oe, halt_out_n, halt_out_oe, bus_fault_n, bus_fault_oe, irq_n, irq_oe
  );
  modport host (
    output addr, host_data, host_data_oe, upper_byte_strobe_n, lower_byte_strobe_n,
           read_not_write, chip_select_n,
    input  dev_data, dev_data_oe, transfer_ack_n, transfer_ack_oe, system_reset_out_n,
           system_reset_out_oe, halt_out_n, halt_out_oe, bus_fault_n, bus_fault_oe, irq_n, irq_oe
  );
endinterface

// ==== verilog/hbsc_host.sv ====
// host end: issues word/byte bus cycles and waits for acknowledge
`timescale 1ns/1ns
module hbsc_host
  import hbsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  hbsc_if.host             bus,
  input  wire logic        req_valid,
  input  wire logic        req_read,
  input  wire logic [21:0] req_addr,
  input  wire logic [1:0]  req_lanes,
  input  wire logic [15:0] req_wdata,
  output logic             req_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_fault
);
  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  hbsc_host_t  state, next_state;
  logic        ack_seen, fault_seen;
  logic [21:0] next_addr;
  logic [15:0] next_wdata, next_rdata;
  logic        next_uds, next_lds, next_rnw, next_cs, next_doe;
  logic        next_ready, next_rsp, next_fault;

  // devices pull low; released lines read high through pull-ups
  assign ack_seen   = bus.transfer_ack_oe && !bus.transfer_ack_n;
  assign fault_seen = bus.bus_fault_oe && !bus.bus_fault_n;

  always_comb
  begin
    next_state = state;
    next_addr  = bus.addr;
    next_wdata = bus.host_data;
    next_uds   = bus.upper_byte_strobe_n;
    next_lds   = bus.lower_byte_strobe_n;
    next_rnw   = bus.read_not_write;
    next_cs    = bus.chip_select_n;
    next_doe   = bus.host_data_oe;
    next_ready = 1'b0;
    next_rsp   = 1'b0;
    next_rdata = rsp_rdata;
    next_fault = rsp_fault;
    unique case (state)
      HBSC_H_IDLE:
      begin
        next_ready = 1'b1;
        if (req_valid && req_ready)
        begin
          next_state = HBSC_H_STROBE;
          next_ready = 1'b0;
          next_addr  = req_addr;
          next_rnw   = req_read;
          next_wdata = req_wdata;
          next_doe   = !req_read;
          next_uds   = !req_lanes[1];
          next_lds   = !req_lanes[0];
          next_cs    = 1'b0;
        end
      end
      HBSC_H_STROBE:
        if (ack_seen || fault_seen)
        begin
          next_rdata = bus.dev_data;
          next_fault = fault_seen;
          next_uds   = 1'b1;
          next_lds   = 1'b1;
          next_cs    = 1'b1;
          next_doe   = 1'b0;
          next_state = HBSC_H_WAIT_REL;
        end
      HBSC_H_WAIT_REL:
        if (!ack_seen)
        begin
          next_rsp   = 1'b1;
          next_state = HBSC_H_IDLE;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state                   <= HBSC_H_IDLE;
      bus.addr                <= '0;
      bus.host_data           <= 16'h0000;
      bus.host_data_oe        <= 1'b0;
      bus.upper_byte_strobe_n <= 1'b1;
      bus.lower_byte_strobe_n <= 1'b1;
      bus.read_not_write      <= 1'b1;
      bus.chip_select_n       <= 1'b1;
      req_ready               <= 1'b0;
      rsp_valid               <= 1'b0;
      rsp_rdata               <= 16'h0000;
      rsp_fault               <= 1'b0;
    end
    else
    begin
      state                   <= next_state;
      bus.addr                <= next_addr;
      bus.host_data           <= next_wdata;
      bus.host_data_oe        <= next_doe;
      bus.upper_byte_strobe_n <= next_uds;
      bus.lower_byte_strobe_n <= next_lds;
      bus.read_not_write      <= next_rnw;
      bus.chip_select_n       <= next_cs;
      req_ready               <= next_ready;
      rsp_valid               <= next_rsp;
      rsp_rdata               <= next_rdata;
      rsp_fault               <= next_fault;
    end
  end
endmodule // hbsc_host

// ==== testbench/hbsc_checker.sv ====
// checker: timing relations on the bus between the host end and the device end
`timescale 1ns/1ns
module hbsc_checker
  import hbsc_pkg::*;
#(
  parameter int WDOG_CYCLES = WDOG_CYC
)(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [21:0] addr,
  input wire logic        chip_select_n,
  input wire logic        read_not_write,
  input wire logic        upper_byte_strobe_n,
  input wire logic        lower_byte_strobe_n,
  input wire logic        dev_data_oe,
  input wire logic        transfer_ack_n,
  input wire logic        transfer_ack_oe,
  input wire logic        system_reset_out_oe,
  input wire logic        halt_out_oe,
  input wire logic        bus_fault_oe,
  input wire logic        irq_oe,
  input wire logic        ack_advance_select,
  input wire logic        watchdog_enable,
  input wire logic        irq_request,
  input wire logic        rom_select_n,
  input wire logic        io_select_n
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic        ack;
  logic        strb;
  logic [15:0] held;
  logic [15:0] next_held;
  assign ack  = transfer_ack_oe && !transfer_ack_n;
  assign strb = !(upper_byte_strobe_n && lower_byte_strobe_n);
  // saturates so a stuck strobe never wraps back to zero
  always_comb next_held = !strb ? 16'h0000 : (held == 16'hFFFF) ? held : held + 16'h0001;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn) held <= 16'h0000;
    else held <= next_held;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_ack_cause: assert property (ack |-> $past(strb) && !$past(chip_select_n))
    else $error("acknowledge without selected strobe");
  a_addr_stable: assert property (strb && $past(strb) |-> $stable(addr))
    else $error("address moved under a strobe");
  a_ack_release: assert property (ack && !strb |=> !ack)
    else $error("acknowledge not released");
  a_ack_fast: assert property ($rose(strb) && !chip_select_n && !system_reset_out_oe && ack_advance_select
    |-> !ack ##[1:2] ack) else $error("fast acknowledge mistimed");
  a_ack_slow: assert property ($rose(strb) && !chip_select_n && !system_reset_out_oe && !ack_advance_select
    |-> !ack [*3] ##[1:2] ack) else $error("slow acknowledge mistimed");
  a_read_drive: assert property ($rose(dev_data_oe) |-> $past(read_not_write) && $past(strb)
    && !$past(chip_select_n)) else $error("data driven outside a read");
  a_write_float: assert property (!read_not_write && !chip_select_n && !$past(read_not_write)
    && !$past(chip_select_n) |-> !dev_data_oe) else $error("data driven during write");
  a_seq_quiet: assert property (system_reset_out_oe |-> !ack && !dev_data_oe)
    else $error("access served during reset sequence");
  a_reset_halt: assert property (system_reset_out_oe == halt_out_oe)
    else $error("reset and halt differ");
  a_irq_follow: assert property (irq_oe == $past(irq_request))
    else $error("interrupt output mismatch");
  a_rom_sel: assert property (!rom_select_n |-> $past(strb) && !$past(chip_select_n))
    else $error("rom select without strobe");
  a_io_sel: assert property (!io_select_n |-> $past(strb) && (($past(addr) & IO_MASK) == IO_BASE))
    else $error("io select outside io area");
  a_fault_late: assert property (bus_fault_oe && strb |-> watchdog_enable && held >= WDOG_CYCLES - 2)
    else $error("bus fault too early");
  a_fault_due: assert property (watchdog_enable && held == WDOG_CYCLES |-> ##[0:2] bus_fault_oe)
    else $error("bus fault missing");
endmodule  // hbsc_checker

// ==== testbench/hbsc_tb.sv ====
// testbench: host end and device end joined, corner and random bus cycles
`timescale 1ns/1ns
module hbsc_tb
  import hbsc_pkg::*;
;
  localparam int                RST_CYC = 8;
  localparam int                WD_CYC  = 16;
  localparam logic [21:0]       AREA_BASE [3] = '{REG_BASE, IO_BASE, ROM_BASE};
  localparam int                AREA_SPAN [3] = '{7, 511, 524287};
  logic        ref_clk;
  logic        resetn;
  logic        reset_in_n;
  logic        ack_advance_select;
  logic        watchdog_enable;
  logic        irq_request;
  logic        req_valid;
  logic        req_read;
  logic [21:0] req_addr;
  logic [1:0]  req_lanes;
  logic [15:0] req_wdata;
  logic        req_ready;
  logic        rsp_valid;
  logic [15:0] rsp_rdata;
  logic        rsp_fault;
  logic        rom_select_n;
  logic        io_select_n;
  logic        rom_shadow;
  logic        bank1_present;
  logic        bank2_present;
  logic        col_strobe_bank1_n;
  logic        col_strobe_bank2_n;
  int          shadow_left;
  logic [15:0] mem [8];
  int          miscompares;
  int          check_count;
  hbsc_if      bus_if ();
  // ----------------------------------------
  // both ends and the checker
  // ----------------------------------------
  hbsc_device #(.RESET_CYCLES(RST_CYC), .WDOG_CYCLES(WD_CYC)) u_hbsc_device (
    .ref_clk, .resetn, .bus(bus_if.device), .reset_in_n, .ack_advance_select, .watchdog_enable,
    .irq_request, .col_strobe_bank1_n, .col_strobe_bank2_n, .rom_select_n, .io_select_n,
    .rom_shadow, .bank1_present, .bank2_present);
  hbsc_host u_hbsc_host (
    .ref_clk, .resetn, .bus(bus_if.host), .req_valid, .req_read, .req_addr, .req_lanes, .req_wdata,
    .req_ready, .rsp_valid, .rsp_rdata, .rsp_fault);
  hbsc_checker #(.WDOG_CYCLES(WD_CYC)) u_hbsc_checker (
    .ref_clk, .resetn, .ack_advance_select, .watchdog_enable, .irq_request, .rom_select_n, .io_select_n,
    .addr(bus_if.addr), .chip_select_n(bus_if.chip_select_n), .read_not_write(bus_if.read_not_write),
    .upper_byte_strobe_n(bus_if.upper_byte_strobe_n), .lower_byte_strobe_n(bus_if.lower_byte_strobe_n),
    .dev_data_oe(bus_if.dev_data_oe), .transfer_ack_n(bus_if.transfer_ack_n),
    .transfer_ack_oe(bus_if.transfer_ack_oe), .system_reset_out_oe(bus_if.system_reset_out_oe),
    .halt_out_oe(bus_if.halt_out_oe), .bus_fault_oe(bus_if.bus_fault_oe), .irq_oe(bus_if.irq_oe));
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: expected %h, got %h", $time, exp, got);
    end
  endtask
  // every while-loop wait goes through here, so no loop can hang the run
  task automatic tick(inout int n);
    @(posedge ref_clk);
    #1;
    n++;
    if (n > 400)
    begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic wait_seq();
    int n;
    n = 0;
    while (bus_if.system_reset_out_oe !== 1'b0) tick(n);
  endtask
  function automatic logic [15:0] exp_read(input logic [21:0] a, input logic [1:0] ln);
    logic [15:0] m;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    if ((a & REG_MASK) != REG_BASE)
      m = 16'h0000;
    return mem[a[2:0]] & m;
  endfunction
  // entered and left just after a rising edge
  task automatic op(input logic rd, input logic [21:0] a, input logic [1:0] ln, input logic [15:0] wd,
                    input logic ef);
    logic [15:0] m;
    int          n;
    logic [1:0]  sel;
    m = {{8{ln[1]}}, {8{ln[0]}}};
    n = 0;
    sel = 2'h0;
    req_read = rd;
    req_addr = a;
    req_lanes = ln;
    req_wdata = wd;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) tick(n);
    tick(n);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1)
    begin
      tick(n);
      sel = sel | {!rom_select_n, !io_select_n};
    end
    check({14'h0000, (a & ROM_MASK) == ROM_BASE || shadow_left > 0, (a & IO_MASK) == IO_BASE},
      {14'h0000, sel});
    check({15'h0000, ef}, {15'h0000, rsp_fault});
    check(16'h001F, {11'h000, bus_if.chip_select_n, bus_if.upper_byte_strobe_n,
      bus_if.lower_byte_strobe_n, !bus_if.transfer_ack_oe, !bus_if.dev_data_oe});
    if (rd && !ef)
      check(exp_read(a, ln), rsp_rdata);
    else if (!ef && (a & REG_MASK) == REG_BASE)
      mem[a[2:0]] = (mem[a[2:0]] & ~m) | (wd & m);
    if (!ef && shadow_left > 0)
      shadow_left--;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    int k;
    ref_clk = 1'b0;
    resetn = 1'b0;
    reset_in_n = 1'b1;
    ack_advance_select = 1'b0;
    watchdog_enable = 1'b1;
    irq_request = 1'b0;
    col_strobe_bank1_n = 1'b1;
    col_strobe_bank2_n = 1'b0;
    shadow_left = SHADOW_FETCHES;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_addr = 22'h000000;
    req_lanes = 2'h0;
    req_wdata = 16'h0000;
    miscompares = 0;
    check_count = 0;
    foreach (mem[i]) mem[i] = RESET_DATA;
    void'($urandom(67));
    repeat (12) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check(16'h0001, {15'h0000, rom_shadow});
    wait_seq();
    check(16'h0001, {14'h0000, bank2_present, bank1_present});
    op(1'b0, REG_BASE + 22'h000007, 2'h2, 16'hA5C3, 1'b0);
    op(1'b0, REG_BASE + 22'h000007, 2'h1, 16'h3C5A, 1'b0);
    op(1'b1, REG_BASE + 22'h000007, 2'h3, 16'h0000, 1'b0);
    op(1'b1, REG_BASE + 22'h000007, 2'h1, 16'h0000, 1'b0);
    check(16'h0000, {15'h0000, rom_shadow});
    for (int i = 0; i < 80; i++)
    begin
      k = $urandom_range(2);
      ack_advance_select = 1'($urandom);
      irq_request = 1'($urandom);
      op(1'($urandom), AREA_BASE[k] | 22'($urandom_range(AREA_SPAN[k])), 2'($urandom_range(3, 1)),
        16'($urandom), 1'b0);
    end
    // a cycle started while the sequence is held must wait for its end
    watchdog_enable = 1'b0;
    reset_in_n = 1'b0;
    shadow_left = SHADOW_FETCHES;
    fork
      op(1'b1, REG_BASE + 22'h000007, 2'h3, 16'h0000, 1'b0);
      begin
        repeat (3 * WD_CYC) @(posedge ref_clk);
        #1;
        reset_in_n = 1'b1;
      end
    join
    watchdog_enable = 1'b1;
    reset_in_n = 1'b0;
    shadow_left = SHADOW_FETCHES;
    col_strobe_bank1_n = 1'b0;
    col_strobe_bank2_n = 1'b1;
    op(1'b1, REG_BASE, 2'h3, 16'h0000, 1'b1);
    reset_in_n = 1'b1;
    wait_seq();
    check(16'h0002, {14'h0000, bank2_present, bank1_present});
    op(1'b0, REG_BASE, 2'h3, 16'h1234, 1'b0);
    op(1'b1, REG_BASE, 2'h3, 16'h0000, 1'b0);
    end_of_test();
  end
endmodule  // hbsc_tb
